// File: design/ckg_top.sv
// Clock generator control: oscillators, CPU clock select, standby gating.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_map.svh"
module ckg_top
  import ckg_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = `CKG_STAB_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // CPU register access
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Standby requests
  input wire logic i_stop_req,
  input wire logic i_halt_req,
  input wire logic i_wake,
  // Clock enables
  output logic o_cpu_ce,
  output logic o_periph_ce,
  output logic o_sub_periph_ce,
  // Status and oscillator controls
  output logic o_cpu_run,
  output logic o_cpu_on_sub,
  output logic o_stop_mode,
  output logic o_halt_mode,
  output logic o_main_osc_en,
  output logic o_sub_osc_en,
  output logic o_fb_res_en
);
  // ====================================================================
  // Register write helpers
  // ====================================================================
  // A bit operation replaces one bit of the present value with bit 0 of
  // the write data; a byte operation replaces the whole byte.
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] data,
                                       input logic bit_op,
                                       input logic [2:0] bit_sel);
    logic [7:0] v;
    v = cur;
    if (bit_op) begin
      v[bit_sel] = data[0];
    end else begin
      v = data;
    end
    return v;
  endfunction

  ckg_top_st_t s;
  ckg_top_st_t next_s;
  ckg_sel_if sel ();
  logic wr_pcc;
  logic wr_sub_osc_mode;
  logic wr_css;
  logic [7:0] pcc_cur;
  logic [7:0] sub_osc_mode_cur;
  logic [7:0] css_cur;
  logic [7:0] pcc_new;
  logic [7:0] sub_osc_mode_new;
  logic [7:0] css_new;
  logic stab_last;
  // Reset image of the processor clock register; the reset branch takes
  // single bits of it so that no wider value is squeezed into a flag.
  localparam logic [7:0] PCC_RST = `CKG_PROC_CLOCK_CTRL_RST;

  // ====================================================================
  // Oscillators and switch
  // ====================================================================
  ckg_osc_div #(
    .DIV(12'(`CKG_MAIN_DIV))
  ) u_main_osc (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(s.main_en),
    .o_ce(sel.main_ce)
  );

  ckg_osc_div #(
    .DIV(12'(`CKG_SUB_DIV))
  ) u_sub_osc (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_run(!s.sub_stop),
    .o_ce(sel.sub_ce)
  );

  ckg_clk_mux u_mux (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .sel(sel.mux)
  );

  assign sel.sel_sub = s.sub_sel;
  assign sel.sel_div4 = s.div4;

  // ====================================================================
  // Register views
  // ====================================================================
  always_comb begin
    pcc_cur = 8'h00;
    pcc_cur[`CKG_MAIN_OSC_STOP_BIT] = s.main_osc_stop;
    pcc_cur[`CKG_CPU_DIV_SEL_BIT] = s.div4;
    sub_osc_mode_cur = 8'h00;
    sub_osc_mode_cur[`CKG_FB_RES_OFF_BIT] = s.fb_off;
    sub_osc_mode_cur[`CKG_SUB_OSC_STOP_BIT] = s.sub_stop;
    css_cur = 8'h00;
    css_cur[`CKG_SUB_SEL_BIT] = s.sub_sel;
    css_cur[`CKG_CPU_ON_SUB_BIT] = sel.on_sub;
  end

  assign wr_pcc = i_wr && (i_addr == `CKG_PROC_CLOCK_CTRL_ADDR);
  assign wr_sub_osc_mode = i_wr && (i_addr == `CKG_SUB_OSC_MODE_ADDR);
  assign wr_css = i_wr && (i_addr == `CKG_SUB_CLOCK_CONTROL_ADDR);
  assign pcc_new = merge(pcc_cur, i_wdata, i_bit_op, i_bit_sel);
  assign sub_osc_mode_new = merge(sub_osc_mode_cur, i_wdata, i_bit_op, i_bit_sel);
  assign css_new = merge(css_cur, i_wdata, i_bit_op, i_bit_sel);
  assign stab_last = (s.stab == 16'(STAB_CYCLES - 1));

  // ====================================================================
  // Next state
  // ====================================================================
  always_comb begin
    next_s = s;
    if (wr_pcc) begin
      next_s.div4 = pcc_new[`CKG_CPU_DIV_SEL_BIT];
      // Stopping the main oscillator under a running main CPU clock would
      // freeze the CPU, so the set is dropped unless on the sub clock.
      if (!pcc_new[`CKG_MAIN_OSC_STOP_BIT]) begin
        next_s.main_osc_stop = 1'b0;
      end else if (sel.on_sub) begin
        next_s.main_osc_stop = 1'b1;
      end
    end
    if (wr_sub_osc_mode) begin
      next_s.fb_off = sub_osc_mode_new[`CKG_FB_RES_OFF_BIT];
      next_s.sub_stop = sub_osc_mode_new[`CKG_SUB_OSC_STOP_BIT];
    end
    if (wr_css) begin
      // The status bit is not stored: writes to it have no effect.
      next_s.sub_sel = css_new[`CKG_SUB_SEL_BIT];
    end
    next_s.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `CKG_PROC_CLOCK_CTRL_ADDR: next_s.rdata = pcc_cur;
        `CKG_SUB_OSC_MODE_ADDR: next_s.rdata = sub_osc_mode_cur;
        `CKG_SUB_CLOCK_CONTROL_ADDR: next_s.rdata = css_cur;
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Standby: stop only while the main clock drives the CPU.
    if (i_wake) begin
      next_s.stop = 1'b0;
      next_s.halt = 1'b0;
    end else if (s.run) begin
      if (i_stop_req && !sel.on_sub) begin
        next_s.stop = 1'b1;
      end
      if (i_halt_req) begin
        next_s.halt = 1'b1;
      end
    end
    next_s.main_en = !next_s.main_osc_stop && !next_s.stop;
    // Stabilisation wait counted in main clock periods after reset.
    if (!s.run && sel.main_ce) begin
      if (stab_last) begin
        next_s.run = 1'b1;
      end else begin
        next_s.stab = s.stab + 16'd1;
      end
    end
    next_s.cpu_ce = sel.cpu_ce && s.run && !s.halt && !s.stop;
    next_s.periph_ce = sel.main_ce;
    next_s.sub_ce = sel.sub_ce;
  end

  // Oscillator enable resets low: the main oscillator stays off while
  // the reset pin is held and starts on the first edge after release.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.div4 <= PCC_RST[`CKG_CPU_DIV_SEL_BIT];
      s.main_en <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ====================================================================
  // Outputs
  // ====================================================================
  assign o_rdata = s.rdata;
  assign o_cpu_ce = s.cpu_ce;
  assign o_periph_ce = s.periph_ce;
  assign o_sub_periph_ce = s.sub_ce;
  assign o_cpu_run = s.run;
  assign o_cpu_on_sub = sel.on_sub;
  assign o_stop_mode = s.stop;
  assign o_halt_mode = s.halt;
  assign o_main_osc_en = s.main_en;
  assign o_sub_osc_en = !s.sub_stop;
  assign o_fb_res_en = !s.fb_off;

  // ====================================================================
  // Checks
  // ====================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence mcc_set_on_main_s;
    wr_pcc && pcc_new[`CKG_MAIN_OSC_STOP_BIT] && !sel.on_sub && !s.main_osc_stop;
  endsequence

  sequence css_read_s;
    i_rd && (i_addr == `CKG_SUB_CLOCK_CONTROL_ADDR);
  endsequence

  mcc_guard_a: assert property (
    mcc_set_on_main_s |=> !s.main_osc_stop ##1 (s.main_en || s.stop))
    else $error("main osc stop taken on main clock");
  stop_refused_a: assert property (
    i_stop_req && sel.on_sub && !s.stop && !i_wake |=> !s.stop)
    else $error("stop standby entered on sub clock");
  osc_off_a: assert property (
    (s.main_osc_stop || s.stop) |-> !s.main_en)
    else $error("main osc running while stopped");
  run_hold_a: assert property (
    !s.run |=> !s.cpu_ce) else $error("CPU clock before wait end");
  css_read_a: assert property (
    css_read_s |=> s.rdata[`CKG_CPU_ON_SUB_BIT] == $past(sel.on_sub)
                   && s.rdata[3:0] == 4'h0)
    else $error("status read wrong");
  periph_main_a: assert property (
    s.periph_ce |-> $past(sel.main_ce) && $past(s.main_en, 2))
    else $error("peripheral clock without main osc");
  sub_osc_mode_write_a: assert property (
    wr_sub_osc_mode && !i_bit_op |=> s.sub_stop == $past(i_wdata[0])
                             && s.fb_off == $past(i_wdata[1]))
    else $error("mode register write lost");
  // A bit write to bit 0 of the mode register must load the sub oscillator stop flag.
  bit_write_a: assert property (
    wr_sub_osc_mode && i_bit_op && i_bit_sel == 3'd0
    |=> s.sub_stop == $past(i_wdata[0]))
    else $error("bit write to mode register lost");
  css_write_a: assert property (
    wr_css && !i_bit_op |=> s.sub_sel == $past(i_wdata[4]))
    else $error("source select write lost");
  mcc_on_sub_a: assert property (
    wr_pcc && pcc_new[`CKG_MAIN_OSC_STOP_BIT] && sel.on_sub
    |=> s.main_osc_stop && !s.main_en)
    else $error("main osc stop refused on sub clock");
  stop_on_main_a: assert property (
    s.run && i_stop_req && !sel.on_sub && !i_wake |=> s.stop && !s.main_en)
    else $error("stop standby refused on main clock");
  halt_gate_a: assert property (
    s.halt |=> !s.cpu_ce)
    else $error("CPU clock running in halt");
  wake_clear_a: assert property (
    i_wake |=> !s.stop && !s.halt)
    else $error("standby kept after wake");
  // The watch and display clocks must come from the sub oscillator only.
  sub_feed_a: assert property (
    s.sub_ce |-> $past(sel.sub_ce))
    else $error("sub peripheral clock without sub osc");
endmodule // ckg_top
`default_nettype wire

// File: design/ckg_map.svh
// Register addresses, field positions, reset values and timing counts.
`ifndef CKG_MAP_SVH
`define CKG_MAP_SVH
`define CKG_SUB_OSC_MODE_ADDR 16'hfff0
`define CKG_SUB_CLOCK_CONTROL_ADDR 16'hfff2
`define CKG_PROC_CLOCK_CTRL_ADDR 16'hfffb
`define CKG_SUB_OSC_MODE_RST 8'h00
`define CKG_SUB_CLOCK_CONTROL_RST 8'h00
`define CKG_PROC_CLOCK_CTRL_RST 8'h02
`define CKG_MAIN_OSC_STOP_BIT 7
`define CKG_CPU_DIV_SEL_BIT 1
`define CKG_FB_RES_OFF_BIT 1
`define CKG_SUB_OSC_STOP_BIT 0
`define CKG_SUB_SEL_BIT 4
`define CKG_CPU_ON_SUB_BIT 5
`define CKG_MCLK_PERIOD_NS 8
`define CKG_MCLK_FREQ_HZ 125000000
`define CKG_MAIN_PERIOD_NS 200
`define CKG_SUB_FREQ_HZ 32768
`define CKG_MAIN_DIV (`CKG_MAIN_PERIOD_NS / `CKG_MCLK_PERIOD_NS)
`define CKG_SUB_DIV (`CKG_MCLK_FREQ_HZ / `CKG_SUB_FREQ_HZ)
`define CKG_STAB_EXP 15
`define CKG_STAB_CYCLES (1 << `CKG_STAB_EXP)
`define CKG_SW_WAIT_SLOW 3'd2
`define CKG_SW_WAIT_FAST 3'd4
`endif

// File: design/ckg_pkg.sv
// Types shared by the clock generator modules.
package ckg_pkg;
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_DIV4 = 2'b01,
    SRC_SUB = 2'b10
  } ckg_src_t;
  typedef struct packed {
    logic [11:0] cnt;
    logic ce;
  } ckg_div_st_t;
  typedef struct packed {
    ckg_src_t src;
    logic [1:0] pre;
    logic [2:0] wait_cnt;
    logic ce;
    logic on_sub;
  } ckg_mux_st_t;
  typedef struct packed {
    logic main_osc_stop;
    logic div4;
    logic fb_off;
    logic sub_stop;
    logic sub_sel;
    logic [7:0] rdata;
    logic main_en;
    logic [15:0] stab;
    logic run;
    logic stop;
    logic halt;
    logic cpu_ce;
    logic periph_ce;
    logic sub_ce;
  } ckg_top_st_t;
endpackage

// File: design/ckg_sel_if.sv
// Clock enables and source selection passed between top and switch.
`timescale 1ns/1ps
`default_nettype none
interface ckg_sel_if;
  logic main_ce;
  logic sub_ce;
  logic sel_sub;
  logic sel_div4;
  logic cpu_ce;
  logic on_sub;
  modport ctl (output sel_sub, output sel_div4,
               input main_ce, input sub_ce, input cpu_ce, input on_sub);
  modport mux (input main_ce, input sub_ce, input sel_sub,
               input sel_div4, output cpu_ce, output on_sub);
endinterface
`default_nettype wire

// File: design/ckg_osc_div.sv
// Oscillator model: divides the master clock into a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module ckg_osc_div
  import ckg_pkg::*;
#(
  parameter logic [11:0] DIV = 12'd25
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  // Enable out
  output logic o_ce
);
  ckg_div_st_t s;
  ckg_div_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.ce = 1'b0;
    if (!i_run) begin
      next_s.cnt = 12'h000;
    end else if (s.cnt == DIV - 12'd1) begin
      next_s.cnt = 12'h000;
      next_s.ce = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 12'd1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_ce = s.ce;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  stopped_osc_quiet_a: assert property (
    !i_run |=> !s.ce ##1 !s.ce) else $error("enable from stopped osc");
endmodule // ckg_osc_div
`default_nettype wire

// File: design/ckg_clk_mux.sv
// Glitch-free CPU clock source switch with delayed changeover.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_map.svh"
module ckg_clk_mux
  import ckg_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Selection and enables
  ckg_sel_if.mux sel
);
  ckg_mux_st_t s;
  ckg_mux_st_t next_s;
  ckg_src_t tgt;
  logic tick;
  logic edge_now;
  logic [1:0] last;
  logic [2:0] need;

  // The source changes only on a CPU clock edge of the old source and
  // the new prescaler restarts, so no shortened period can appear.
  always_comb begin
    next_s = s;
    tgt = sel.sel_sub ? SRC_SUB : (sel.sel_div4 ? SRC_DIV4 : SRC_MAIN);
    tick = (s.src == SRC_SUB) ? sel.sub_ce : sel.main_ce;
    case (s.src)
      SRC_MAIN: last = 2'd0;
      SRC_DIV4: last = 2'd3;
      SRC_SUB: last = 2'd1;
      default: last = 2'd0;
    endcase
    need = (s.src == SRC_MAIN && tgt == SRC_DIV4) ?
           `CKG_SW_WAIT_FAST : `CKG_SW_WAIT_SLOW;
    edge_now = tick && (s.pre == last);
    next_s.ce = edge_now;
    if (edge_now) begin
      next_s.pre = 2'd0;
    end else if (tick) begin
      next_s.pre = s.pre + 2'd1;
    end
    if (tgt == s.src) begin
      next_s.wait_cnt = 3'd0;
    end else if (edge_now) begin
      if (s.wait_cnt == need - 3'd1) begin
        next_s.src = tgt;
        next_s.wait_cnt = 3'd0;
      end else begin
        next_s.wait_cnt = s.wait_cnt + 3'd1;
      end
    end
    next_s.on_sub = (next_s.src == SRC_SUB);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{src: SRC_MAIN, pre: 2'd0, wait_cnt: 3'd0, ce: 1'b0,
             on_sub: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign sel.cpu_ce = s.ce;
  assign sel.on_sub = s.on_sub;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  switch_on_edge_a: assert property (
    $changed(s.src) |-> s.ce && s.src == $past(tgt))
    else $error("source changed off a clock edge");
  status_follows_a: assert property (
    $changed(s.src) |-> s.on_sub == (s.src == SRC_SUB))
    else $error("status bit not tracking source");
endmodule // ckg_clk_mux
`default_nettype wire

// File: bench/ckg_cpu_model.sv
// CPU-side model: register bus writes, reads and standby requests.
`timescale 1ns/1ps
`default_nettype none
module ckg_cpu_model (
  // Clock and read return
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  // Register bus
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic o_bit_op,
  output logic [2:0] o_bit_sel,
  output logic [7:0] o_wdata,
  // Standby requests
  output logic o_stop_req,
  output logic o_halt_req,
  output logic o_wake
);
  initial begin
    {o_wr, o_rd, o_stop_req, o_halt_req, o_wake} = '0;
  end
  // Software clears reserved bits; raw writes exist only to probe refusals.
  function automatic logic [7:0] keep(logic [15:0] a, logic [7:0] d);
    case (a)
      16'hfffb: keep = d & 8'h82;
      16'hfff0: keep = d & 8'h03;
      16'hfff2: keep = d & 8'h30;
      default: keep = d;
    endcase
  endfunction
  task automatic wr(logic [15:0] a, logic [7:0] d, logic raw);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= raw ? d : keep(a, d);
    o_bit_op <= 1'b0;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
  endtask
  task automatic bwr(logic [15:0] a, logic [2:0] b, logic v);
    @(posedge i_mclk);
    o_addr <= a;
    o_bit_sel <= b;
    o_wdata <= {7'h00, v};
    o_bit_op <= 1'b1;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
  // Kind 0 asks stop, 1 asks halt, 2 wakes.
  task automatic req(int k);
    @(posedge i_mclk);
    o_stop_req <= (k == 0);
    o_halt_req <= (k == 1);
    o_wake <= (k == 2);
    @(posedge i_mclk);
    {o_stop_req, o_halt_req, o_wake} <= 3'b000;
    @(posedge i_mclk);
    #1;
  endtask
endmodule // ckg_cpu_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the clock generator control block.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_map.svh"
module tb;
  localparam int MAIN_GAP = `CKG_MAIN_DIV;
  localparam int SUB_GAP = 2 * `CKG_SUB_DIV;
  localparam logic [15:0] A_MODE = `CKG_SUB_OSC_MODE_ADDR;
  localparam logic [15:0] A_CTL = `CKG_SUB_CLOCK_CONTROL_ADDR;
  localparam logic [15:0] A_PROC = `CKG_PROC_CLOCK_CTRL_ADDR;
  logic i_mclk, i_rst_n, wr, rd, bop, stp, hlt, wake;
  logic [15:0] addr;
  logic [2:0] bsel;
  logic [7:0] wdata, rdata, d;
  logic cpu_ce, per_ce, sub_ce, run, on_sub, stop_m, halt_m;
  logic main_en, sub_en, fb_en;
  int err_count, checked, n, p, q;
  ckg_top #(.STAB_CYCLES(8)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_bit_op(bop), .i_bit_sel(bsel),
    .i_wdata(wdata), .o_rdata(rdata), .i_stop_req(stp), .i_halt_req(hlt),
    .i_wake(wake), .o_cpu_ce(cpu_ce), .o_periph_ce(per_ce),
    .o_sub_periph_ce(sub_ce), .o_cpu_run(run), .o_cpu_on_sub(on_sub),
    .o_stop_mode(stop_m), .o_halt_mode(halt_m), .o_main_osc_en(main_en),
    .o_sub_osc_en(sub_en), .o_fb_res_en(fb_en));
  ckg_cpu_model cpu (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_bit_op(bop), .o_bit_sel(bsel),
    .o_wdata(wdata), .o_stop_req(stp), .o_halt_req(hlt), .o_wake(wake));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(logic [15:0] a, logic [7:0] e);
    cpu.rd(a, d);
    chk("register read", {8'h00, e}, {8'h00, d});
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    #1;
    for (int k = 0; k < lim && s !== v; k++) begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  // Cycles between two CPU enables, measured from the next one seen.
  task automatic gap(output int g);
    wt(cpu_ce, 1'b1, 20000);
    g = 0;
    do begin
      @(posedge i_mclk);
      #1;
      g++;
    end while (cpu_ce !== 1'b1 && g < 20000);
  endtask
  task automatic cnt(input int c, output int a, output int b);
    a = 0;
    b = 0;
    repeat (c) begin
      @(posedge i_mclk);
      #1;
      a += (per_ce === 1'b1);
      b += (sub_ce === 1'b1);
    end
  endtask
  task automatic t_stab();
    p = 0;
    repeat (150) begin
      @(posedge i_mclk);
      #1;
      p += (cpu_ce !== 1'b0);
    end
    chk("cpu enables in wait", 0, p);
    chk("run early", 0, run);
    wt(run, 1'b1, 100);
    chk("run after wait", 1, run);
    chk("main osc on", 1, main_en);
  endtask
  task automatic t_regs();
    rchk(A_MODE, 8'h00);
    rchk(A_CTL, 8'h00);
    rchk(A_PROC, 8'h02);
    rchk(16'hfff1, 8'h00);
    cpu.wr(A_PROC, 8'h82, 0);
    rchk(A_PROC, 8'h02);
    chk("main osc kept", 1, main_en);
    cpu.wr(A_CTL, 8'h20, 1);
    rchk(A_CTL, 8'h00);
    cpu.wr(A_MODE, 8'hff, 1);
    rchk(A_MODE, 8'h03);
    chk("sub osc off", 0, sub_en);
    chk("resistor off", 0, fb_en);
    cpu.bwr(A_MODE, 3'h0, 1'b0);
    rchk(A_MODE, 8'h02);
    chk("sub osc on", 1, sub_en);
    cpu.bwr(A_MODE, 3'h1, 1'b0);
    rchk(A_MODE, 8'h00);
    chk("resistor on", 1, fb_en);
  endtask
  task automatic t_speed();
    gap(n);
    chk("slow main period", 4 * MAIN_GAP, n);
    cpu.wr(A_PROC, 8'h00, 0);
    gap(n);
    chk("period just after write", 4 * MAIN_GAP, n);
    repeat (400) @(posedge i_mclk);
    gap(n);
    chk("fast main period", MAIN_GAP, n);
    cnt(10 * MAIN_GAP, p, q);
    chk("peripheral enables", 10, p);
  endtask
  task automatic t_stop();
    cpu.req(0);
    chk("stop on main", 1, stop_m);
    chk("main osc in stop", 0, main_en);
    cnt(100, p, q);
    chk("peripherals in stop", 0, p);
    cpu.req(2);
    chk("stop left", 0, stop_m);
    chk("main osc after wake", 1, main_en);
    cpu.req(1);
    chk("halt on main", 1, halt_m);
    cpu.req(2);
    chk("halt left", 0, halt_m);
  endtask
  task automatic t_sub();
    cpu.wr(A_CTL, 8'h10, 0);
    chk("status before switch", 0, on_sub);
    wt(on_sub, 1'b1, 200);
    chk("status on sub", 1, on_sub);
    rchk(A_CTL, 8'h30);
    gap(n);
    chk("sub period", SUB_GAP, n);
    cpu.req(0);
    chk("stop on sub", 0, stop_m);
    cpu.req(1);
    chk("halt on sub", 1, halt_m);
    cpu.req(2);
    cpu.wr(A_PROC, 8'h80, 0);
    rchk(A_PROC, 8'h80);
    chk("main osc stopped", 0, main_en);
    cnt(4000, p, q);
    chk("peripherals stopped", 0, p);
    chk("sub peripherals run", 1, q != 0);
    cpu.wr(A_PROC, 8'h00, 0);
    rchk(A_PROC, 8'h00);
    chk("main osc restarted", 1, main_en);
    cpu.wr(A_CTL, 8'h00, 0);
    wt(on_sub, 1'b0, 20000);
    chk("status back on main", 0, on_sub);
  endtask
  task automatic final_report();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    err_count = 0;
    checked = 0;
    i_rst_n = 1'b0;
    repeat (7) @(posedge i_mclk);
    #1;
    chk("main osc in reset", 0, main_en);
    chk("sub osc in reset", 1, sub_en);
    chk("resistor in reset", 1, fb_en);
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_stab();
    t_regs();
    t_speed();
    t_stop();
    t_sub();
    final_report();
  end
  // The run needs about 31000 cycles; this cuts a hang well beyond that.
  initial begin
    repeat (60000) @(posedge i_mclk);
    err_count++;
    final_report();
  end
endmodule // tb
`default_nettype wire
